// ---- rtl/bfs_pkg.sv ----
// Shared constants, timing figures and types of the buck fault supervisor.
`default_nettype none
package bfs_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;     // 20 MHz system clock.
  localparam int T_EN_DELAY_NS = 20000;  // Enable to reference slewing, 20 us.
  localparam int T_OC_FILT_NS = 10000;   // Overcurrent filter, 10 us.
  localparam int T_OV_FILT_NS = 2000;    // Overvoltage filters, 2 us.
  localparam int T_UV_FILT_NS = 2000;    // Undervoltage filter, 2 us.

  // Least times round up to whole cycles and never come to less than one.
  function automatic int ns_to_cyc_up(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int EN_DLY_CYC = ns_to_cyc_up(T_EN_DELAY_NS);
  localparam int OC_FILT_CYC = ns_to_cyc_up(T_OC_FILT_NS);
  localparam int OV_FILT_CYC = ns_to_cyc_up(T_OV_FILT_NS);
  localparam int UV_FILT_CYC = ns_to_cyc_up(T_UV_FILT_NS);

  // Width of every counter; holds the longest count above.
  localparam int CNT_W = 9;

  // ---------------------------------------------------------------
  // Positions of the synchronised inputs
  // ---------------------------------------------------------------
  localparam int IN_SUP = 0;   // Supply above reset threshold.
  localparam int IN_EN = 1;    // Enable pin above threshold.
  localparam int IN_OC = 2;    // Overcurrent sense above output sense.
  localparam int IN_OVR = 3;   // Feedback above rising overvoltage level.
  localparam int IN_OVF = 4;   // Feedback below falling overvoltage level.
  localparam int IN_UV = 5;    // Feedback below undervoltage level.
  localparam int IN_OT = 6;    // Over-temperature comparator.
  localparam int IN_SS = 7;    // Soft-start current has tapered off.
  localparam int IN_W = 8;
  localparam logic [IN_W-1:0] SYNC_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_OFF   = 5'h01,
    ST_DLY   = 5'h02,
    ST_SS    = 5'h04,
    ST_RUN   = 5'h08,
    ST_LATCH = 5'h10
  } bfs_state_t;

  typedef enum logic [1:0] {
    PG_GOOD = 2'h0,
    PG_SSUV = 2'h1,
    PG_OV   = 2'h2,
    PG_OC   = 2'h3
  } bfs_pg_t;

  localparam bfs_state_t ST_RESET = ST_OFF;
  localparam bfs_pg_t PG_RESET = PG_SSUV;

endpackage
`default_nettype wire

// ---- rtl/bfs_filter.sv ----
// Continuous-level filter: qualifies a comparator level held for a count of cycles.
`default_nettype none
module bfs_filter
  import bfs_pkg::*;
#(
  parameter logic [CNT_W-1:0] LIMIT = 9'h028
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic level_in,
  output logic qualified
);

  // ---------------------------------------------------------------
  // Run counter
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] cnt_r;   // Consecutive cycles the level has been high.
  logic [CNT_W-1:0] cnt_nxt; // Next count.

  // The count restarts on any low sample, so a glitch never adds up.
  always_comb begin
    if (!level_in) begin
      cnt_nxt = '0;
    end else if (cnt_r == LIMIT) begin
      cnt_nxt = cnt_r; // Saturate so the qualified level holds.
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  // Register the count.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Qualified once the level has stood for the whole filter time.
  assign qualified = (cnt_r == LIMIT);

  // Qualification needs an unbroken run of high samples.
  filt_run_a: assert property (@(posedge clk) disable iff (rst)
    $rose(qualified) |-> $past(level_in) && $past(level_in, 2))
    else $error("filter qualified without a run of high samples");

endmodule
`default_nettype wire

// ---- rtl/bfs_supervisor.sv ----
// Soft-start sequencer and fault supervisor for a single-phase buck controller.
`default_nettype none
module bfs_supervisor
  import bfs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic supply_ok,
  input wire logic enable_in,
  input wire logic oc_above_cmp,
  input wire logic ov_rise_cmp,
  input wire logic ov_fall_cmp,
  input wire logic uv_below_cmp,
  input wire logic over_temp_cmp,
  input wire logic ss_taper_cmp,
  input wire logic pwm_high_req,
  input wire logic pwm_low_req,
  input wire logic dem_req,
  output logic soft_start_reference_clamp_release,
  output logic ref_amp_enable,
  output logic soft_start_done_flag,
  output logic [1:0] power_good_indicator,
  output logic high_side_gate_drive,
  output logic low_side_gate_drive,
  output logic diode_emulation_mode,
  output logic continuous_conduction_mode,
  output logic overcurrent_fault,
  output logic overvoltage_fault,
  output logic undervoltage_fault,
  output logic over_temp_state
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [IN_W-1:0] raw_in;   // Pin and comparator levels, asynchronous.
  logic [IN_W-1:0] sync1_r;  // First stage, read only by the second.
  logic [IN_W-1:0] sync2_r;  // Second stage, safe for logic.

  assign raw_in = {ss_taper_cmp, over_temp_cmp, uv_below_cmp, ov_fall_cmp,
                   ov_rise_cmp, oc_above_cmp, enable_in, supply_ok};

  // Every comparator is analog and asynchronous, so all pass two flops.
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= SYNC_RESET;
      sync2_r <= SYNC_RESET;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  logic sup_s; // Supply above threshold, synchronised.
  logic en_s;  // Enable high, synchronised.
  logic ot_s;  // Over-temperature, synchronised.
  logic ss_s;  // Soft-start taper detected, synchronised.
  assign sup_s = sync2_r[IN_SUP];
  assign en_s = sync2_r[IN_EN];
  assign ot_s = sync2_r[IN_OT];
  assign ss_s = sync2_r[IN_SS];

  // ---------------------------------------------------------------
  // Comparator filters
  // ---------------------------------------------------------------
  logic oc_q;  // Overcurrent held for the filter time.
  logic ovr_q; // Feedback above rising overvoltage level for the filter time.
  logic ovf_q; // Feedback below falling overvoltage level for the filter time.
  logic uv_q;  // Feedback below undervoltage level for the filter time.

  bfs_filter #(.LIMIT(CNT_W'(OC_FILT_CYC))) u_oc_filt (
    .clk(clk),
    .rst(rst),
    .level_in(sync2_r[IN_OC]),
    .qualified(oc_q)
  );

  bfs_filter #(.LIMIT(CNT_W'(OV_FILT_CYC))) u_ovr_filt (
    .clk(clk),
    .rst(rst),
    .level_in(sync2_r[IN_OVR]),
    .qualified(ovr_q)
  );

  bfs_filter #(.LIMIT(CNT_W'(OV_FILT_CYC))) u_ovf_filt (
    .clk(clk),
    .rst(rst),
    .level_in(sync2_r[IN_OVF]),
    .qualified(ovf_q)
  );

  bfs_filter #(.LIMIT(CNT_W'(UV_FILT_CYC))) u_uv_filt (
    .clk(clk),
    .rst(rst),
    .level_in(sync2_r[IN_UV]),
    .qualified(uv_q)
  );

  // ---------------------------------------------------------------
  // Sequencer and fault state
  // ---------------------------------------------------------------
  bfs_state_t st_r;             // Sequencer state.
  bfs_state_t st_nxt;
  logic [CNT_W-1:0] dly_cnt_r;  // Enable-to-slew delay counter.
  logic [CNT_W-1:0] dly_cnt_nxt;
  logic oc_r;                   // Overcurrent latch.
  logic oc_nxt;
  logic ov_r;                   // Overvoltage latch.
  logic ov_nxt;
  logic uv_r;                   // Undervoltage latch.
  logic uv_nxt;
  logic ot_r;                   // Over-temperature state.
  logic ot_nxt;
  logic dis_r;                  // Low-side discharge while overvoltage is latched.
  logic dis_nxt;
  logic active;                 // Reference is up and detectors watch.
  logic clr_ou;                 // Clears overcurrent, undervoltage, temperature.
  logic clr_ov;                 // Clears overvoltage.
  logic oc_set;
  logic ov_set;
  logic uv_set;
  logic any_set;

  // Detectors run in soft-start and in regulation, whether or not the
  // temperature state has suspended switching.
  always_comb begin
    active = (st_r == ST_SS) || (st_r == ST_RUN);
    clr_ou = !en_s || !sup_s;
    clr_ov = !sup_s;
    oc_set = active && oc_q;
    ov_set = (active || (st_r == ST_LATCH)) && ovr_q;
    uv_set = active && uv_q;
    any_set = oc_set || ov_set || uv_set;
    // A set in the clearing cycle wins over the clear.
    oc_nxt = oc_set || (oc_r && !clr_ou);
    ov_nxt = ov_set || (ov_r && !clr_ov);
    uv_nxt = uv_set || (uv_r && !clr_ou);
    // Temperature never latches: it follows the comparator and drops on
    // enable or supply loss.
    ot_nxt = ot_s && !clr_ou;
    // Discharge toggles only while overvoltage is latched.
    if (!ov_nxt) begin
      dis_nxt = 1'b0;
    end else if (ovr_q) begin
      dis_nxt = 1'b1;
    end else if (ovf_q) begin
      dis_nxt = 1'b0;
    end else begin
      dis_nxt = dis_r;
    end
    st_nxt = st_r;
    dly_cnt_nxt = dly_cnt_r;
    unique case (st_r)
      ST_OFF: begin
        dly_cnt_nxt = '0;
        if (sup_s && en_s && !oc_r && !ov_r && !uv_r) begin
          st_nxt = ST_DLY;
        end
      end
      ST_DLY: begin
        if (clr_ou) begin
          st_nxt = ST_OFF;
        end else if (dly_cnt_r == CNT_W'(EN_DLY_CYC - 1)) begin
          st_nxt = ST_SS;
        end else begin
          dly_cnt_nxt = dly_cnt_r + 1'b1;
        end
      end
      ST_SS: begin
        if (any_set) begin
          st_nxt = ST_LATCH;
        end else if (clr_ou) begin
          st_nxt = ST_OFF;
        end else if (ss_s) begin
          st_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (any_set) begin
          st_nxt = ST_LATCH;
        end else if (clr_ou) begin
          st_nxt = ST_OFF;
        end
      end
      ST_LATCH: begin
        // Stay off until every latch has been cleared by its own cause.
        if (!oc_nxt && !ov_nxt && !uv_nxt) begin
          st_nxt = ST_OFF;
        end
      end
      default: begin
        st_nxt = ST_RESET;
      end
    endcase
  end

  // Register sequencer and fault state.
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= ST_RESET;
      dly_cnt_r <= '0;
      oc_r <= 1'b0;
      ov_r <= 1'b0;
      uv_r <= 1'b0;
      ot_r <= 1'b0;
      dis_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      dly_cnt_r <= dly_cnt_nxt;
      oc_r <= oc_nxt;
      ov_r <= ov_nxt;
      uv_r <= uv_nxt;
      ot_r <= ot_nxt;
      dis_r <= dis_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Output drive
  // ---------------------------------------------------------------
  logic ref_up_nxt;
  logic done_nxt;
  logic switching_nxt;
  logic hs_nxt;
  logic ls_nxt;
  logic dem_nxt;
  bfs_pg_t pg_nxt;

  // Outputs are computed from next state so they line up with it.
  always_comb begin
    ref_up_nxt = (st_nxt == ST_SS) || (st_nxt == ST_RUN);
    done_nxt = (st_nxt == ST_RUN);
    switching_nxt = ref_up_nxt && !ot_nxt;
    // The low request wins so both gates are never asked high together.
    hs_nxt = switching_nxt && pwm_high_req && !pwm_low_req;
    if (ot_nxt) begin
      ls_nxt = 1'b0;
    end else if (ov_nxt) begin
      ls_nxt = dis_nxt;
    end else begin
      ls_nxt = switching_nxt && pwm_low_req;
    end
    dem_nxt = done_nxt && switching_nxt && dem_req;
    // Temperature is left out on purpose: it must not change the code.
    if (oc_nxt) begin
      pg_nxt = PG_OC;
    end else if (ov_nxt) begin
      pg_nxt = PG_OV;
    end else if (uv_nxt || !done_nxt) begin
      pg_nxt = PG_SSUV;
    end else begin
      pg_nxt = PG_GOOD;
    end
  end

  // Register every output so the pins never see decode glitches.
  always_ff @(posedge clk) begin
    if (rst) begin
      soft_start_reference_clamp_release <= 1'b0;
      ref_amp_enable <= 1'b0;
      soft_start_done_flag <= 1'b0;
      power_good_indicator <= PG_RESET;
      high_side_gate_drive <= 1'b0;
      low_side_gate_drive <= 1'b0;
      diode_emulation_mode <= 1'b0;
      continuous_conduction_mode <= 1'b1;
      overcurrent_fault <= 1'b0;
      overvoltage_fault <= 1'b0;
      undervoltage_fault <= 1'b0;
      over_temp_state <= 1'b0;
    end else begin
      soft_start_reference_clamp_release <= ref_up_nxt;
      ref_amp_enable <= ref_up_nxt;
      soft_start_done_flag <= done_nxt;
      power_good_indicator <= pg_nxt;
      high_side_gate_drive <= hs_nxt;
      low_side_gate_drive <= ls_nxt;
      diode_emulation_mode <= dem_nxt;
      continuous_conduction_mode <= !dem_nxt;
      overcurrent_fault <= oc_nxt;
      overvoltage_fault <= ov_nxt;
      undervoltage_fault <= uv_nxt;
      over_temp_state <= ot_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_uv_declared;
    $rose(undervoltage_fault) ##0 (!overcurrent_fault && !overvoltage_fault);
  endsequence

  sequence s_ss_entry;
    $rose(st_r == ST_SS);
  endsequence

  ref_delay_a: assert property (s_ss_entry |-> $past(en_s, EN_DLY_CYC) &&
    $past(st_r == ST_DLY, EN_DLY_CYC) && soft_start_reference_clamp_release && ref_amp_enable)
    else $error("reference released without the enable delay");

  ss_release_a: assert property (soft_start_reference_clamp_release |-> en_s || $past(en_s))
    else $error("reference clamp released with enable low");

  // The flag rises two edges after the last counted sample, so the run of
  // high samples ends two edges back and starts a filter length plus one edges back.
  oc_filter_a: assert property ($rose(overcurrent_fault) |->
    $past(sync2_r[IN_OC], 2) && $past(sync2_r[IN_OC], OC_FILT_CYC + 1))
    else $error("overcurrent declared before its filter time");

  oc_code_a: assert property (overcurrent_fault |->
    power_good_indicator == PG_OC && !high_side_gate_drive)
    else $error("overcurrent code or latch-off missing");

  oc_hold_a: assert property (overcurrent_fault && en_s && sup_s |=> overcurrent_fault)
    else $error("overcurrent cleared without enable or supply loss");

  ov_filter_a: assert property ($rose(overvoltage_fault) |->
    $past(sync2_r[IN_OVR], 2) && $past(sync2_r[IN_OVR], OV_FILT_CYC + 1))
    else $error("overvoltage declared before its filter time");

  ov_hold_a: assert property (overvoltage_fault && sup_s |=> overvoltage_fault)
    else $error("overvoltage cleared while supply stayed up");

  ls_off_a: assert property (overvoltage_fault && ovf_q && !ovr_q |=>
    overvoltage_fault |-> !low_side_gate_drive)
    else $error("discharge not ended below falling threshold");

  uv_code_a: assert property (s_uv_declared |->
    power_good_indicator == PG_SSUV && st_r == ST_LATCH)
    else $error("undervoltage code or latch-off missing");

  ot_gates_a: assert property (over_temp_state |->
    !high_side_gate_drive && !low_side_gate_drive)
    else $error("gate drive active in over-temperature");

  dem_gate_a: assert property (diode_emulation_mode |->
    soft_start_done_flag && !continuous_conduction_mode)
    else $error("diode emulation before soft-start done");

endmodule
`default_nettype wire

// ---- sim/bfs_plant_model.sv ----
// Behavioural model of the comparators and power stage around the supervisor.
`default_nettype none
module bfs_plant_model
  import bfs_pkg::*;
#(
  parameter int SS_CYC = 30,  // Cycles for the reference capacitor to charge.
  parameter int DIS_CYC = 60  // Cycles of low-side discharge that pull the output back.
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_start_reference_clamp_release,
  input wire logic low_side_gate_drive,
  input wire logic oc_cmd,
  input wire logic ov_kick,
  input wire logic uv_cmd,
  input wire logic hot_cmd,
  output logic oc_above_cmp,
  output logic ov_rise_cmp,
  output logic ov_fall_cmp,
  output logic uv_below_cmp,
  output logic over_temp_cmp,
  output logic ss_taper_cmp
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [8:0] ss_cnt_r, ss_cnt_nxt;    // Charge reached on the reference capacitor.
  logic [8:0] dis_cnt_r, dis_cnt_nxt;  // Time spent discharging the output.
  logic fb_hi_r, fb_hi_nxt;            // Output sits above the overvoltage band.

  // ---------------------------------------------------------------
  // Plant state
  // ---------------------------------------------------------------
  // A closed clamp empties the capacitor, so every start charges it anew.
  // The output only falls while the low side is really on, never by itself.
  always_comb begin
    ss_cnt_nxt = ss_cnt_r;
    dis_cnt_nxt = 9'h000;
    fb_hi_nxt = fb_hi_r;
    if (!soft_start_reference_clamp_release) begin
      ss_cnt_nxt = 9'h000;
    end else if (ss_cnt_r < SS_CYC[8:0]) begin
      ss_cnt_nxt = ss_cnt_r + 9'h001;
    end
    if (low_side_gate_drive && fb_hi_r) begin
      dis_cnt_nxt = dis_cnt_r + 9'h001;
    end
    if (dis_cnt_r == DIS_CYC[8:0]) begin
      fb_hi_nxt = 1'b0;
    end
    if (ov_kick) begin
      fb_hi_nxt = 1'b1;
    end
  end

  // Registers only; the supply detector reset empties everything.
  always_ff @(posedge clk) begin
    if (rst) begin
      ss_cnt_r <= 9'h000;
      dis_cnt_r <= 9'h000;
      fb_hi_r <= 1'b0;
    end else begin
      ss_cnt_r <= ss_cnt_nxt;
      dis_cnt_r <= dis_cnt_nxt;
      fb_hi_r <= fb_hi_nxt;
    end
  end

  // Regulated feedback sits under the falling overvoltage level.
  assign ss_taper_cmp = (ss_cnt_r == SS_CYC[8:0]);
  assign ov_rise_cmp = fb_hi_r;
  assign ov_fall_cmp = !fb_hi_r;
  assign oc_above_cmp = oc_cmd;
  assign uv_below_cmp = uv_cmd;
  assign over_temp_cmp = hot_cmd;
endmodule
`default_nettype wire

// ---- sim/tb_bfs_supervisor.sv ----
// Self-checking testbench of the buck fault supervisor.
`default_nettype none
module tb_bfs_supervisor import bfs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int SS_CYC = 30;   // Soft-start length in the plant.
  localparam int DIS_CYC = 60;  // Discharge length in the plant.
  localparam int W = 8;         // Slack for synchronisers and output registers.

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic supply_ok = 1'b0, enable_in = 1'b0, pwm_high_req = 1'b0, pwm_low_req = 1'b0, dem_req = 1'b0;
  logic oc_cmd = 1'b0, ov_kick = 1'b0, uv_cmd = 1'b0, hot_cmd = 1'b0;
  logic oc_above_cmp, ov_rise_cmp, ov_fall_cmp, uv_below_cmp, over_temp_cmp, ss_taper_cmp;
  logic soft_start_reference_clamp_release, ref_amp_enable, soft_start_done_flag, high_side_gate_drive, low_side_gate_drive;
  logic diode_emulation_mode, continuous_conduction_mode, overcurrent_fault, overvoltage_fault;
  logic undervoltage_fault, over_temp_state;
  logic [1:0] power_good_indicator;
  logic [31:0] seed = 32'h0000000E;  // Fixed seed keeps every run the same.
  int mismatches = 0;
  int samples_checked = 0;

  always #25 clk = ~clk;

  bfs_supervisor i_bfs_supervisor (.clk(clk), .rst(rst), .supply_ok(supply_ok), .enable_in(enable_in),
    .oc_above_cmp(oc_above_cmp), .ov_rise_cmp(ov_rise_cmp), .ov_fall_cmp(ov_fall_cmp),
    .uv_below_cmp(uv_below_cmp), .over_temp_cmp(over_temp_cmp), .ss_taper_cmp(ss_taper_cmp),
    .pwm_high_req(pwm_high_req), .pwm_low_req(pwm_low_req), .dem_req(dem_req),
    .soft_start_reference_clamp_release(soft_start_reference_clamp_release), .ref_amp_enable(ref_amp_enable),
    .soft_start_done_flag(soft_start_done_flag), .power_good_indicator(power_good_indicator),
    .high_side_gate_drive(high_side_gate_drive), .low_side_gate_drive(low_side_gate_drive),
    .diode_emulation_mode(diode_emulation_mode), .continuous_conduction_mode(continuous_conduction_mode),
    .overcurrent_fault(overcurrent_fault), .overvoltage_fault(overvoltage_fault),
    .undervoltage_fault(undervoltage_fault), .over_temp_state(over_temp_state));

  bfs_plant_model #(.SS_CYC(SS_CYC), .DIS_CYC(DIS_CYC)) i_bfs_plant_model (.clk(clk), .rst(rst),
    .soft_start_reference_clamp_release(soft_start_reference_clamp_release), .low_side_gate_drive(low_side_gate_drive), .oc_cmd(oc_cmd),
    .ov_kick(ov_kick), .uv_cmd(uv_cmd), .hot_cmd(hot_cmd), .oc_above_cmp(oc_above_cmp),
    .ov_rise_cmp(ov_rise_cmp), .ov_fall_cmp(ov_fall_cmp), .uv_below_cmp(uv_below_cmp),
    .over_temp_cmp(over_temp_cmp), .ss_taper_cmp(ss_taper_cmp));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Xorshift source for the modulator requests.
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Selects a watched output by number, so one wait task serves them all.
  function automatic logic pick(input int sel);
    case (sel)
      0: return soft_start_reference_clamp_release;
      1: return soft_start_done_flag;
      2: return overcurrent_fault;
      3: return overvoltage_fault;
      4: return undervoltage_fault;
      5: return low_side_gate_drive;
      default: return over_temp_state;
    endcase
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [1:0] got, input logic [1:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Counts falling edges until the output shows val; the count must land in [lo, hi].
  task automatic wait_sig(input int sel, input logic val, input int lo, input int hi);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (pick(sel) !== val && n <= hi);
    samples_checked++;
    if (n < lo || n > hi) begin
      mismatches++;
      $display("CHECK FAILED at %0t: output %0d took %0d cycles", $time, sel, n);
    end
  endtask

  // Random requests; gates and mode follow one edge later; when on is low the gates stay off and the mode stays continuous.
  task automatic gates_run(input int n, input logic on);
    logic ph, pl, pd;
    logic [31:0] r;
    repeat (n) begin
      @(posedge clk);
      ph = pwm_high_req;
      pl = pwm_low_req;
      pd = dem_req;
      r = rnd();
      pwm_high_req <= r[0];
      pwm_low_req <= r[1];
      dem_req <= r[2];
      @(negedge clk);
      chk({high_side_gate_drive, low_side_gate_drive}, on ? {ph & !pl, pl} : 2'h0, "gates");
      chk({diode_emulation_mode, continuous_conduction_mode}, on ? {pd, !pd} : 2'h1, "mode");
    end
  endtask

  task automatic kick();
    @(posedge clk);
    ov_kick <= 1'b1;
    @(posedge clk);
    ov_kick <= 1'b0;
  endtask

  // Raises supply and enable, then follows the start-up to the end of soft-start.
  task automatic start();
    @(posedge clk);
    supply_ok <= 1'b1;
    enable_in <= 1'b1;
    dem_req <= 1'b1;
    wait_sig(0, 1'b1, EN_DLY_CYC, EN_DLY_CYC + W);
    repeat (5) @(negedge clk);
    chk({ref_amp_enable, soft_start_done_flag}, 2'h2, "reference in soft-start");
    chk(power_good_indicator, PG_SSUV, "code in soft-start");
    chk({diode_emulation_mode, continuous_conduction_mode}, 2'h1, "mode in soft-start");
    wait_sig(1, 1'b1, SS_CYC - 5, SS_CYC + W);
    chk(power_good_indicator, PG_GOOD, "code after soft-start");
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({continuous_conduction_mode, |{soft_start_reference_clamp_release, high_side_gate_drive, low_side_gate_drive,
      diode_emulation_mode, overcurrent_fault, overvoltage_fault, undervoltage_fault}}, 2'h2, "reset");
    chk(power_good_indicator, PG_SSUV, "reset code");
    start();
    gates_run(40, 1'b1);
    @(posedge clk);
    hot_cmd <= 1'b1;
    wait_sig(6, 1'b1, 1, W);
    gates_run(20, 1'b0);
    chk(power_good_indicator, PG_GOOD, "code in over-temperature");
    chk({overcurrent_fault | overvoltage_fault | undervoltage_fault, soft_start_done_flag}, 2'h1, "no latch");
    @(posedge clk);
    hot_cmd <= 1'b0;
    wait_sig(6, 1'b0, 1, W);
    gates_run(20, 1'b1);
    // Two pulses just short of the filter must not add up.
    repeat (2) begin
      @(posedge clk);
      oc_cmd <= 1'b1;
      repeat (OC_FILT_CYC - 4) @(posedge clk);
      oc_cmd <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (W) @(negedge clk);
    chk({overcurrent_fault, soft_start_done_flag}, 2'h1, "short overcurrent");
    @(posedge clk);
    oc_cmd <= 1'b1;
    wait_sig(2, 1'b1, OC_FILT_CYC, OC_FILT_CYC + W);
    chk(power_good_indicator, PG_OC, "overcurrent code");
    gates_run(10, 1'b0);
    chk({soft_start_reference_clamp_release, ref_amp_enable}, 2'h0, "latched off");
    kick();
    wait_sig(3, 1'b1, OV_FILT_CYC, OV_FILT_CYC + W);
    chk(power_good_indicator, PG_OC, "overcurrent outranks");
    for (int i = 0; i < 2; i++) begin
      if (i > 0) begin
        kick();
      end
      wait_sig(5, 1'b1, (i > 0) ? OV_FILT_CYC : 1, OV_FILT_CYC + W);
      wait_sig(5, 1'b0, DIS_CYC + OV_FILT_CYC, DIS_CYC + OV_FILT_CYC + W);
    end
    @(posedge clk);
    oc_cmd <= 1'b0;
    enable_in <= 1'b0;
    wait_sig(2, 1'b0, 1, W);
    chk({overvoltage_fault, overcurrent_fault}, 2'h2, "overvoltage kept");
    chk(power_good_indicator, PG_OV, "overvoltage code");
    @(posedge clk);
    supply_ok <= 1'b0;
    wait_sig(3, 1'b0, 1, W);
    start();
    @(posedge clk);
    hot_cmd <= 1'b1;
    wait_sig(6, 1'b1, 1, W);
    @(posedge clk);
    uv_cmd <= 1'b1;
    wait_sig(4, 1'b1, UV_FILT_CYC, UV_FILT_CYC + W);
    chk(power_good_indicator, PG_SSUV, "undervoltage code");
    chk({soft_start_reference_clamp_release, over_temp_state}, 2'h1, "undervoltage latched off");
    @(posedge clk);
    enable_in <= 1'b0;
    wait_sig(4, 1'b0, 1, W);
    wait_sig(6, 1'b0, 1, W);
    @(posedge clk);
    uv_cmd <= 1'b0;
    hot_cmd <= 1'b0;
    start();
    kick();
    wait_sig(3, 1'b1, OV_FILT_CYC, OV_FILT_CYC + W);
    chk(power_good_indicator, PG_OV, "overvoltage code");
    chk({soft_start_reference_clamp_release, soft_start_done_flag}, 2'h0, "overvoltage latched off");
    close_out();
  end

  // Watchdog: the whole sequence needs about 2500 cycles.
  initial begin
    repeat (10000) @(posedge clk);
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
